//--- core/eep_pkg.sv
// Purpose: shared constants and types of the two-wire eeprom slave front end
// Assumes: 10 MHz system clock, 8192 x 8 memory in 32-byte pages
// Notes:   shared figures live here once; eep_slave logic refers to them by scoped name, its checks repeat 8 and 32 as literals
package eep_pkg;

  // ==========================================================
  // memory organisation
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned PAGE_OFS_W = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned MEM_WORDS  = 8192;
  localparam logic [7:0]  MEM_INIT   = 8'hFF;

  // ==========================================================
  // slave address layout
  localparam logic [3:0] DEV_TYPE    = 4'hA;
  localparam int unsigned DEV_TYPE_LSB = 4;
  localparam int unsigned SEL_LSB    = 1;
  localparam int unsigned DIR_BIT    = 0;
  localparam logic [2:0] SEL_FIXED   = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // timing
  localparam int unsigned PROGRAM_CYCLE_TIME_NS = 4_000_000;
  localparam int unsigned CLK_PERIOD_NS         = 100;
  localparam int unsigned PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] sel;
  } eep_pins_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} eep_state_t;
  typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} eep_kind_t;

endpackage

//--- core/eep_slave.sv
// Purpose: two-wire slave of a byte-organised serial eeprom, 32-byte page writes
// Assumes: i_link_clk oversamples the bus; sda drive is open drain via o_sda_oe
// Notes:   programming timer runs on i_clk, protocol and memory on i_link_clk
`timescale 1ns/1ns
module eep_slave #(
  parameter int unsigned PROG_CYCLES  = eep_pkg::PROG_CYCLES,
  parameter bit          HAS_SEL_PINS = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_link_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_wp,
  input  wire logic i_addr_select_bit0,
  input  wire logic i_addr_select_bit1,
  input  wire logic i_addr_select_bit2,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  output logic      o_prog_busy
);

  localparam int unsigned AW = eep_pkg::ADDR_W;
  localparam int unsigned OW = eep_pkg::PAGE_OFS_W;
  localparam int unsigned CW = $clog2(PROG_CYCLES + 1);

  generate
    if (PROG_CYCLES < 9) begin : g_bad_prog
      $error("PROG_CYCLES must be at least 9");
    end
  endgenerate

  // ==========================================================
  // link domain: reset and pin synchronisers
  logic              lrst_m_q, lrst_q;
  eep_pkg::eep_pins_t pins_raw, pins_m_q, pins_s_q;
  logic              scl_p_q, sda_p_q;

  assign pins_raw = '{scl: i_scl, sda: i_sda, wp: i_wp,
                      sel: {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0}};

  always_ff @(posedge i_link_clk) begin
    lrst_m_q <= i_reset;
    lrst_q   <= lrst_m_q;
    pins_m_q <= pins_raw;
    pins_s_q <= pins_m_q;
    scl_p_q  <= pins_s_q.scl;
    sda_p_q  <= pins_s_q.sda;
  end

  wire scl_rise = pins_s_q.scl & ~scl_p_q;
  wire scl_fall = ~pins_s_q.scl & scl_p_q;
  wire start_w  = pins_s_q.scl & scl_p_q & sda_p_q & ~pins_s_q.sda;
  wire stop_w   = pins_s_q.scl & scl_p_q & ~sda_p_q & pins_s_q.sda;
  wire [2:0] sel_w = HAS_SEL_PINS ? pins_s_q.sel : eep_pkg::SEL_FIXED;

  // ==========================================================
  // link domain: protocol state
  eep_pkg::eep_state_t st_q;
  eep_pkg::eep_kind_t  kind_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q, txb_q;
  logic                oe_q, sda_o_q, mack_q, wp_lat_q;
  logic [AW-1:0]       addr_q;

  // delivery state only; contents survive reset like the real array
  logic [7:0]            mem [eep_pkg::MEM_WORDS] = '{default: eep_pkg::MEM_INIT};
  logic [7:0]            pbuf [eep_pkg::PAGE_BYTES];
  logic [eep_pkg::PAGE_BYTES-1:0] mask_q;
  logic                  commit_q;
  logic [OW-1:0]         cidx_q;
  logic [AW-OW-1:0]      cpage_q;
  logic                  req_tgl_q, done_m_q, done_s_q;
  logic                  done_tgl_q;

  wire busy_l    = commit_q | (req_tgl_q != done_s_q);
  wire dev_match = (shift_q[7:eep_pkg::DEV_TYPE_LSB] == eep_pkg::DEV_TYPE)
                 & (shift_q[eep_pkg::SEL_LSB +: 3] == sel_w);
  wire rd_dir    = shift_q[eep_pkg::DIR_BIT];
  wire byte_done = (st_q == eep_pkg::ST_RX) & scl_fall & (cnt_q == eep_pkg::BITS_PER_BYTE);
  wire ack_end   = (st_q == eep_pkg::ST_ACK) & scl_fall;
  // busy device stays silent so the master can poll
  wire ack_w     = (kind_q == eep_pkg::K_DEV)  ? (dev_match & ~busy_l) :
                   (kind_q == eep_pkg::K_DATA) ? ~wp_lat_q : 1'b1;
  wire data_wr   = byte_done & (kind_q == eep_pkg::K_DATA) & ~wp_lat_q;
  wire ld_rd     = (ack_end & oe_q & (kind_q == eep_pkg::K_DEV) & rd_dir)
                 | ((st_q == eep_pkg::ST_RACK) & scl_fall & mack_q);
  wire [7:0] rd_byte = mem[addr_q];
  wire new_write = ack_end & oe_q & (kind_q == eep_pkg::K_DEV) & ~rd_dir;
  wire go_commit = stop_w & (|mask_q) & ~commit_q;

  always_ff @(posedge i_link_clk) begin
    if (lrst_q) begin
      st_q    <= eep_pkg::ST_IDLE;
      kind_q  <= eep_pkg::K_DEV;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
      sda_o_q <= 1'b0;
      mack_q  <= 1'b0;
      shift_q <= 8'h00;
      txb_q   <= 8'h00;
    end else if (start_w) begin
      st_q   <= eep_pkg::ST_RX;
      kind_q <= eep_pkg::K_DEV;
      cnt_q  <= 4'h0;
      oe_q   <= 1'b0;
    end else if (stop_w) begin
      st_q <= eep_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        eep_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], pins_s_q.sda};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byte_done) begin
            st_q <= eep_pkg::ST_ACK;
            oe_q <= ack_w;
          end
        end
        eep_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (!oe_q) begin
              st_q <= eep_pkg::ST_IDLE;
            end else if (ld_rd) begin
              st_q  <= eep_pkg::ST_TX;
              txb_q <= rd_byte;
              oe_q  <= ~rd_byte[7];
              cnt_q <= 4'h1;
            end else begin
              st_q   <= eep_pkg::ST_RX;
              oe_q   <= 1'b0;
              kind_q <= (kind_q == eep_pkg::K_DEV) ? eep_pkg::K_AHI :
                        (kind_q == eep_pkg::K_AHI) ? eep_pkg::K_ALO : eep_pkg::K_DATA;
            end
          end
        end
        eep_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == eep_pkg::BITS_PER_BYTE) begin
              st_q <= eep_pkg::ST_RACK;
              oe_q <= 1'b0;
            end else begin
              oe_q  <= ~txb_q[6];
              txb_q <= {txb_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        eep_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_q <= ~pins_s_q.sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              st_q  <= eep_pkg::ST_TX;
              txb_q <= rd_byte;
              oe_q  <= ~rd_byte[7];
              cnt_q <= 4'h1;
            end else begin
              st_q <= eep_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // link domain: address pointer and write-protect latch
  always_ff @(posedge i_link_clk) begin
    if (lrst_q) begin
      addr_q   <= '0;
      wp_lat_q <= 1'b0;
    end else begin
      if (byte_done && kind_q == eep_pkg::K_AHI) begin
        addr_q[AW-1:8] <= shift_q[AW-9:0];
      end else if (byte_done && kind_q == eep_pkg::K_ALO) begin
        addr_q[7:0] <= shift_q;
      end else if (data_wr) begin
        addr_q[OW-1:0] <= addr_q[OW-1:0] + 1'b1;
      end else if (ld_rd) begin
        addr_q <= addr_q + 1'b1;
      end
      if (ack_end && kind_q == eep_pkg::K_ALO) begin
        wp_lat_q <= pins_s_q.wp;
      end
    end
  end

  // ==========================================================
  // link domain: page buffer and commit walker
  always_ff @(posedge i_link_clk) begin
    if (lrst_q) begin
      mask_q    <= '0;
      commit_q  <= 1'b0;
      cidx_q    <= '0;
      cpage_q   <= '0;
      req_tgl_q <= 1'b0;
    end else begin
      if (new_write) begin
        mask_q <= '0;
      end else if (data_wr) begin
        mask_q[addr_q[OW-1:0]] <= 1'b1;
      end else if (go_commit) begin
        mask_q <= mask_q;
      end else if (commit_q && cidx_q == '1) begin
        mask_q <= '0;
      end
      if (go_commit) begin
        commit_q <= 1'b1;
        cidx_q   <= '0;
        cpage_q  <= addr_q[AW-1:OW];
      end else if (commit_q) begin
        cidx_q <= cidx_q + 1'b1;
        if (cidx_q == '1) begin
          commit_q  <= 1'b0;
          req_tgl_q <= ~req_tgl_q;
        end
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (data_wr) begin
      pbuf[addr_q[OW-1:0]] <= shift_q;
    end
    if (commit_q && mask_q[cidx_q]) begin
      mem[{cpage_q, cidx_q}] <= pbuf[cidx_q];
    end
    done_m_q <= done_tgl_q;
    done_s_q <= done_m_q;
  end

  assign o_sda_o  = sda_o_q;
  assign o_sda_oe = oe_q;

  // ==========================================================
  // system domain: programming cycle timer
  logic          req_m_q, req_s_q, req_seen_q, prog_busy_q;
  logic [CW-1:0] pcnt_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      req_m_q     <= 1'b0;
      req_s_q     <= 1'b0;
      req_seen_q  <= 1'b0;
      prog_busy_q <= 1'b0;
      pcnt_q      <= '0;
      done_tgl_q  <= 1'b0;
    end else begin
      req_m_q <= req_tgl_q;
      req_s_q <= req_m_q;
      if (req_s_q != req_seen_q) begin
        req_seen_q  <= req_s_q;
        prog_busy_q <= 1'b1;
        pcnt_q      <= CW'(PROG_CYCLES - 1);
      end else if (prog_busy_q) begin
        if (pcnt_q == '0) begin
          prog_busy_q <= 1'b0;
          done_tgl_q  <= ~done_tgl_q;
        end else begin
          pcnt_q <= pcnt_q - 1'b1;
        end
      end
    end
  end

  assign o_prog_busy = prog_busy_q;

  // ==========================================================
  // checks
  a_open_drain_low: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    o_sda_oe |-> !o_sda_o) else $error("sda driven high");
  a_drive_on_fall: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    $changed(oe_q) |-> $past(scl_fall | start_w | stop_w)) else $error("sda moved off fall");
  a_stable_high: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    (pins_s_q.scl && scl_p_q) |-> $stable(oe_q) || $past(start_w | stop_w))
    else $error("sda changed while scl high");
  a_ack_ninth: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    $rose(st_q == eep_pkg::ST_ACK) |-> $past(cnt_q) == 4'h8) else $error("ack not on ninth");
  a_addr_match: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    (st_q == eep_pkg::ST_ACK && kind_q == eep_pkg::K_DEV && oe_q)
    |-> shift_q[7:4] == eep_pkg::DEV_TYPE && shift_q[3:1] == sel_w)
    else $error("acked foreign address");
  a_wp_reject: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    (st_q == eep_pkg::ST_ACK && kind_q == eep_pkg::K_DATA && wp_lat_q) |-> !oe_q)
    else $error("protected data acked");
  a_page_latched: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    $past(data_wr) |-> addr_q[AW-1:OW] == $past(addr_q[AW-1:OW])) else $error("page moved");
  a_read_wrap: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    ld_rd |=> addr_q == AW'($past(addr_q) + 1)) else $error("read address step wrong");
  a_commit_start: assert property (@(posedge i_link_clk) disable iff (lrst_q)
    go_commit |=> commit_q ##32 !commit_q) else $error("commit length wrong");
  a_prog_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(prog_busy_q) |-> prog_busy_q [*8]) else $error("program cycle too short");

endmodule

//--- test/eep_master_model.sv
// Purpose: behavioural two-wire bus master facing the eeprom slave
// Assumes: one bus phase is 3 system clocks (10 link clocks)
// Notes:   o_sda high means released; the bench resolves the wire
`timescale 1ns/1ns
module eep_master_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // ==========================================================
  // bus phases
  initial begin
    o_scl = 1'b1; // idle: both lines released
    o_sda = 1'b1;
  end

  task automatic phase(input logic scl, input logic sda);
    repeat (3) @(posedge i_clk);
    #1;
    o_scl = scl;
    o_sda = sda;
  endtask

  // every operation first drops scl with sda held, so no false start or stop
  task automatic start_cond();
    phase(1'b0, o_sda);
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0); // sda falls while scl high
  endtask

  task automatic stop_cond();
    phase(1'b0, o_sda);
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1); // sda rises while scl high
  endtask

  task automatic bit_io(input logic b, output logic s);
    phase(1'b0, o_sda);
    phase(1'b0, b);
    phase(1'b1, b); // sda held through scl high
    s = i_sda;
  endtask

  // ==========================================================
  // byte transfers
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s); // release for the ninth clock
    ack = ~s;
  endtask

  task automatic read_byte(input logic ack_in, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack_in, s);
  endtask
endmodule

//--- test/eep_slave_tb.sv
// Purpose: self-checking bench of the two-wire eeprom slave
// Assumes: straps 101, shortened programming timer
// Notes:   expectations come from the memory map, not from the design
`timescale 1ns/1ns
module eep_slave_tb;
  localparam int unsigned PROG  = 200;
  localparam logic [7:0]  DEV_W = 8'hAA;
  localparam logic [7:0]  DEV_R = 8'hAB;

  logic       clk;
  logic       link_clk;
  logic       reset;
  logic       wp;
  logic [2:0] sel;
  logic       scl;
  logic       m_sda;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic       fx_sda_o;
  logic       fx_sda_oe;
  logic       ack;
  logic [7:0] d;
  int         error_cnt;
  int         cmp_count;
  int         cyc;
  wire        sda = m_sda & (sda_oe ? sda_o : 1'b1) & (fx_sda_oe ? fx_sda_o : 1'b1); // pull-up

  eep_slave #(.PROG_CYCLES(PROG), .HAS_SEL_PINS(1'b1)) eep_slave_inst (
    .i_clk(clk), .i_reset(reset), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
    .i_wp(wp), .i_addr_select_bit0(sel[0]), .i_addr_select_bit1(sel[1]),
    .i_addr_select_bit2(sel[2]), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_prog_busy(busy));

  // pinless variant on the same bus: straps tied high must be ignored
  eep_slave #(.PROG_CYCLES(PROG), .HAS_SEL_PINS(1'b0)) eep_slave_fixed_inst (
    .i_clk(clk), .i_reset(reset), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
    .i_wp(1'b0), .i_addr_select_bit0(1'b1), .i_addr_select_bit1(1'b1),
    .i_addr_select_bit2(1'b1), .o_sda_o(fx_sda_o), .o_sda_oe(fx_sda_oe), .o_prog_busy());

  eep_master_model eep_master_model_inst (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  // ==========================================================
  // clocks and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  initial begin
    cyc = 0;
    forever @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
        error_cnt++;
        $display("timeout after %0d cycles", cyc);
        print_verdict();
      end
    end
  end

  // ==========================================================
  // compare and access tasks
  task automatic check_ack(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic exp, input string what);
    eep_master_model_inst.write_byte(b, ack);
    check_ack(what, exp, ack);
  endtask

  task automatic rd(input logic [7:0] exp, input logic ack_in, input string what);
    eep_master_model_inst.read_byte(ack_in, d);
    check_byte(what, exp, d);
  endtask

  task automatic addr_phase(input logic [15:0] a);
    eep_master_model_inst.start_cond();
    wr(DEV_W, 1'b1, "dev ack");
    wr(a[15:8], 1'b1, "hi ack");
    wr(a[7:0], 1'b1, "lo ack");
  endtask

  task automatic rd_start();
    eep_master_model_inst.start_cond();
    wr(DEV_R, 1'b1, "read dev ack");
  endtask

  // the first try lands inside the programming cycle
  task automatic poll();
    int n;
    eep_master_model_inst.start_cond();
    eep_master_model_inst.write_byte(DEV_W, ack);
    check_ack("busy nack", 1'b0, ack);
    check_ack("prog busy", 1'b1, busy);
    n = 0;
    while (ack !== 1'b1 && n < 40) begin
      eep_master_model_inst.stop_cond();
      eep_master_model_inst.start_cond();
      eep_master_model_inst.write_byte(DEV_W, ack);
      n++;
    end
    check_ack("poll ack", 1'b1, ack);
    eep_master_model_inst.stop_cond();
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    logic [7:0] bad[2];
    error_cnt = 0;
    cmp_count = 0;
    reset = 1'b1;
    wp = 1'b0;
    sel = 3'b101;
    bad = '{8'hBA, 8'hA8};
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (10) @(posedge clk);
    foreach (bad[i]) begin
      eep_master_model_inst.start_cond();
      wr(bad[i], 1'b0, "foreign addr");
      eep_master_model_inst.stop_cond();
    end
    eep_master_model_inst.start_cond();
    wr(8'hA0, 1'b1, "fixed select ack");
    eep_master_model_inst.stop_cond();
    rd_start();
    rd(8'hFF, 1'b0, "delivered byte");
    eep_master_model_inst.stop_cond();
    $display("test addressing done");
    addr_phase(16'hE000);
    wr(8'h5A, 1'b1, "data ack");
    wr(8'h3C, 1'b1, "data ack");
    eep_master_model_inst.stop_cond();
    poll();
    addr_phase(16'h005E);
    wr(8'h11, 1'b1, "data ack");
    wr(8'h22, 1'b1, "data ack");
    wr(8'h33, 1'b1, "wrap ack");
    wr(8'h44, 1'b1, "wrap ack");
    eep_master_model_inst.stop_cond();
    poll();
    addr_phase(16'h005E);
    rd_start();
    rd(8'h11, 1'b1, "byte 005e");
    rd(8'h22, 1'b1, "byte 005f");
    rd(8'hFF, 1'b0, "byte 0060");
    eep_master_model_inst.stop_cond();
    addr_phase(16'h0040);
    rd_start();
    rd(8'h33, 1'b1, "byte 0040");
    rd(8'h44, 1'b0, "byte 0041");
    eep_master_model_inst.stop_cond();
    $display("test page write done");
    wp = 1'b1;
    addr_phase(16'h0100);
    wr(8'h00, 1'b0, "protected data");
    eep_master_model_inst.stop_cond();
    wp = 1'b0;
    addr_phase(16'h0100);
    rd_start();
    rd(8'hFF, 1'b0, "byte 0100");
    eep_master_model_inst.stop_cond();
    $display("test write protect done");
    addr_phase(16'h1FFF);
    rd_start();
    rd(8'hFF, 1'b1, "byte 1fff");
    rd(8'h5A, 1'b0, "byte 0000");
    eep_master_model_inst.stop_cond();
    rd_start();
    rd(8'h3C, 1'b0, "byte 0001");
    eep_master_model_inst.stop_cond();
    $display("test sequential read done");
    print_verdict();
  end
endmodule
